// *** hw/acspi_consts.svh ***
// Offsets, field positions, reset values and response codes of the SPI command block
`ifndef ACSPI_CONSTS_SVH
`define ACSPI_CONSTS_SVH

// =============================================================
// Frame and register map
`define ACSPI_WORD_BITS 5'h10
`define ACSPI_EDGE_SAT 5'h1f
`define ACSPI_ADDR_DEVICE_CONTROL 8'h0e
`define ACSPI_ADDR_STATUS 8'h0f
`define ACSPI_DEVICE_CONTROL_RST 8'h00
`define ACSPI_CE_BIT 0
`define ACSPI_ST_LSB 1
`define ACSPI_ST_MSB 2
`define ACSPI_RESET_CMD 16'h0400

// =============================================================
// Parity bit positions in the response word
`define ACSPI_ACC_PBIT 4'hc
`define ACSPI_REG_PBIT 4'ha

// =============================================================
// Reserved acceleration values
`define ACSPI_ACC_CRIT 11'h7ff
`define ACSPI_ACC_AXIS 11'h7fe
`define ACSPI_ACC_CLK 11'h002
`define ACSPI_ACC_PAR 11'h001

// =============================================================
// Register status codes, ranked by priority
`define ACSPI_SC_CLK 8'h01
`define ACSPI_SC_PAR 8'h02
`define ACSPI_SC_DATA 8'h03
`define ACSPI_SC_OSC 8'h04
`define ACSPI_SC_INIT 8'h05
`define ACSPI_SC_RESET 8'h06
`define ACSPI_SC_TEMP 8'h07
`define ACSPI_SC_OFFX 8'h08
`define ACSPI_SC_OFFY 8'h09
`define ACSPI_SC_AXIS 8'h0a

// =============================================================
// Sample buffer
`define ACSPI_FIFO_DEPTH 32

`endif

// *** hw/acspi_pkg.sv ***
// Types shared by the SPI command block and its sample buffer
package acspi_pkg;

	// =============================================================
	// Transfer type field of the command word
	typedef enum logic [1:0] {
		ACSPI_XT_REG = 2'b00,
		ACSPI_XT_X = 2'b01,
		ACSPI_XT_Y = 2'b10,
		ACSPI_XT_BAD = 2'b11
	} acspi_xfer_t;

	// Exception class, also the class field of register responses
	typedef enum logic [1:0] {
		ACSPI_EC_NONE = 2'b00,
		ACSPI_EC_BEH = 2'b01,
		ACSPI_EC_CRIT = 2'b10,
		ACSPI_EC_TRANS = 2'b11
	} acspi_class_t;

	// Frame state
	typedef enum logic {
		ACSPI_IDLE = 1'b0,
		ACSPI_FRAME = 1'b1
	} acspi_state_t;

	// One filtered sample from the datapath
	typedef struct packed {
		logic axis_y;
		logic [10:0] value;
	} acspi_sample_t;

endpackage

// *** hw/acspi_fifo.sv ***
// Sample FIFO with valid/ready on both sides
`timescale 1ns/100ps

module acspi_fifo #(
	parameter int WIDTH = 12,
	parameter int DEPTH = 32
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Fill side
	input wire logic in_valid,
	input wire logic [WIDTH-1:0] in_data,
	output logic in_ready,
	// Drain side
	output logic out_valid,
	output logic [WIDTH-1:0] out_data,
	input wire logic out_ready
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wr_ptr, next_wr_ptr, rd_ptr, next_rd_ptr;
	logic [AW:0] count, next_count;
	logic next_in_ready, push, pop;

	// =============================================================
	// Pointers and fill level; DEPTH must be a power of two so pointers wrap
	always_comb begin
		push = in_valid && in_ready;
		pop = out_valid && out_ready;
		next_wr_ptr = push ? wr_ptr + 1'b1 : wr_ptr;
		next_rd_ptr = pop ? rd_ptr + 1'b1 : rd_ptr;
		next_count = count + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
		next_in_ready = (next_count != (AW+1)'(DEPTH)); // Registered so ready never loops back
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count <= '0;
			in_ready <= 1'b0;
		end else begin
			wr_ptr <= next_wr_ptr;
			rd_ptr <= next_rd_ptr;
			count <= next_count;
			in_ready <= next_in_ready;
		end
	end

	// Storage holds no reset; contents are qualified by count
	always_ff @(posedge clk) begin
		if (push) begin
			mem[wr_ptr] <= in_data;
		end
	end

	assign out_valid = (count != '0);
	assign out_data = mem[rd_ptr];

endmodule

// *** hw/acspi_core.sv ***
// Command decoder and response formatter behind the 16-bit SPI slave port
// Contract
// RULE1 - Rank exceptions: clock, parity, data, oscillator, init, reset, temp, axis, hold/self-test.
// RULE2 - Offset faults on both axes at once report only the X-axis fault.
// RULE3 - Hold and self-test share one level; both together cancel each other out.
// RULE4 - Every transfer is sixteen bits; transfer type sits in the top two bits.
// RULE5 - Type 00 register, 01 X read, 10 Y read, 11 unused.
// RULE6 - Type 11 raises an invalid axis exception.
// RULE7 - Pointer or data writes are dropped when their transfer detects an exception.
// RULE8 - Highest class decides; transient sets all status bits and returns a code.
// RULE9 - Reset or critical without transient: status bits set, acceleration reads all ones.
// RULE10 - Self-test or high hold input is behavioral: flags change, data does not.
// RULE11 - One behavioral exception: acceleration bit 15 set; register bits 15:13 and 8 set.
// RULE12 - Hold and self-test both active give the normal response format.
// RULE13 - Master encodes register commands in bits 13, 12, 10 and 7:0.
// RULE14 - Acceleration response: zero, type, parity, eleven-bit sample, zero.
// RULE15 - Register responses carry pointer, data or address with parity per operation.
// RULE16 - Only device control at its fixed address accepts writes.
// RULE17 - Writes to other registers are ignored silently without any fault.
// RULE18 - Without exceptions return requested register or sample in normal format.
// RULE19 - Slave with clock idle low, sample on first edge, MSB first.
// RULE20 - Command words need odd parity, else a parity fault shows next transfer.
// RULE21 - Every normal response word carries an odd number of ones.
// RULE22 - Clock fault when rising edge count differs from 16 or clock high at select.
// RULE23 - Transient faults latch during one transfer, report on the next, then clear.
`timescale 1ns/100ps
`include "acspi_consts.svh"

module acspi_core (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// SPI pins
	input wire logic sclk,
	input wire logic cs_n,
	input wire logic mosi,
	output logic miso,
	output logic miso_oe_n,
	// Acceleration sample stream
	input wire logic sample_valid,
	input wire acspi_pkg::acspi_sample_t sample_data,
	output logic sample_ready,
	// Fault and condition inputs
	input wire logic fuse_integrity_flag,
	input wire logic osc_fault,
	input wire logic init_pending_flag,
	input wire logic overtemp_detect,
	input wire logic offset_fault_x,
	input wire logic offset_fault_y,
	input wire logic capture_hold_input
);
	logic sclk_m, sclk_s, sclk_d, cs_m, cs_s, cs_d, mosi_m, mosi_s, hold_m, hold_s;
	logic sclk_rise, sclk_fall, frame_start, frame_end;
	acspi_pkg::acspi_state_t state, next_state;
	logic [15:0] shift_in, next_shift_in, shift_out, next_shift_out, last_cmd, next_last_cmd;
	logic [4:0] edge_cnt, next_edge_cnt;
	logic sclk_hi_fault, next_sclk_hi_fault, next_miso, next_miso_oe_n;
	logic [7:0] pointer, next_pointer, device_control, next_device_control, rdata, code;
	logic reset_latched_flag, next_reset_latched_flag, overtemp_flag, next_overtemp_flag;
	logic t_clk, next_t_clk, t_par, next_t_par, t_axis, next_t_axis, ce_write;
	logic [10:0] x_value, next_x_value, y_value, next_y_value, acc_value;
	logic clk_f, par_f, axis_f, xfer_exc, crit, trans, beh_one, selftest_active, is_acc;
	logic fifo_valid, fifo_ready;
	acspi_pkg::acspi_sample_t fifo_out;
	acspi_pkg::acspi_class_t cls;
	logic [15:0] resp_word;

	// =============================================================
	// Pin synchronisers; only the second stage and its delayed copy feed logic
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			{sclk_m, sclk_s, sclk_d} <= 3'h0;
			{cs_m, cs_s, cs_d} <= 3'h7;
			{mosi_m, mosi_s, hold_m, hold_s} <= 4'h0;
		end else begin
			sclk_m <= sclk;
			sclk_s <= sclk_m;
			sclk_d <= sclk_s;
			cs_m <= cs_n;
			cs_s <= cs_m;
			cs_d <= cs_s;
			mosi_m <= mosi;
			mosi_s <= mosi_m;
			hold_m <= capture_hold_input;
			hold_s <= hold_m;
		end
	end

	// Edges of the sampled link clock and select
	assign sclk_rise = sclk_s && !sclk_d; // RULE19
	assign sclk_fall = !sclk_s && sclk_d; // RULE19
	assign frame_start = cs_d && !cs_s;
	assign frame_end = !cs_d && cs_s;

	// =============================================================
	// Frame shifter: capture on rise, launch on fall, MSB first
	always_comb begin
		next_state = state;
		next_shift_in = shift_in;
		next_shift_out = shift_out;
		next_edge_cnt = edge_cnt;
		next_sclk_hi_fault = sclk_hi_fault;
		next_miso = miso;
		next_miso_oe_n = miso_oe_n;
		next_last_cmd = last_cmd;
		unique case (state)
			acspi_pkg::ACSPI_IDLE: begin
				if (frame_start) begin
					next_state = acspi_pkg::ACSPI_FRAME;
					next_sclk_hi_fault = sclk_s; // RULE22
					next_edge_cnt = 5'h00;
					next_shift_out = resp_word;
					next_miso = osc_fault | resp_word[15]; // Dead oscillator holds the line high
					next_miso_oe_n = 1'b0;
				end
			end
			acspi_pkg::ACSPI_FRAME: begin
				if (sclk_rise) begin
					next_shift_in = {shift_in[14:0], mosi_s}; // RULE19
					if (edge_cnt != `ACSPI_EDGE_SAT) begin
						next_edge_cnt = edge_cnt + 5'h01; // RULE22
					end
				end
				if (sclk_fall) begin
					next_shift_out = {shift_out[14:0], 1'b0};
					next_miso = osc_fault | shift_out[14];
				end
				if (frame_end) begin
					next_state = acspi_pkg::ACSPI_IDLE;
					next_miso = 1'b0;
					next_miso_oe_n = 1'b1;
					next_last_cmd = shift_in; // Answered in the next frame
				end
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			state <= acspi_pkg::ACSPI_IDLE;
			shift_in <= 16'h0000;
			shift_out <= 16'h0000;
			edge_cnt <= 5'h00;
			sclk_hi_fault <= 1'b0;
			miso <= 1'b0;
			miso_oe_n <= 1'b1;
			last_cmd <= `ACSPI_RESET_CMD;
		end else begin
			state <= next_state;
			shift_in <= next_shift_in;
			shift_out <= next_shift_out;
			edge_cnt <= next_edge_cnt;
			sclk_hi_fault <= next_sclk_hi_fault;
			miso <= next_miso;
			miso_oe_n <= next_miso_oe_n;
			last_cmd <= next_last_cmd;
		end
	end

	// =============================================================
	// Command checks and execution at the close of a frame
	assign clk_f = sclk_hi_fault || (edge_cnt != `ACSPI_WORD_BITS); // RULE22 RULE4
	assign par_f = ~^shift_in; // RULE20
	assign axis_f = (shift_in[15:14] == acspi_pkg::ACSPI_XT_BAD); // RULE6 RULE5
	assign xfer_exc = clk_f || par_f || axis_f;
	assign selftest_active = |device_control[`ACSPI_ST_MSB:`ACSPI_ST_LSB]; // RULE10
	assign fifo_ready = (state == acspi_pkg::ACSPI_IDLE); // Stall draining during a frame

	always_comb begin
		next_pointer = pointer;
		next_device_control = device_control;
		next_t_clk = t_clk;
		next_t_par = t_par;
		next_t_axis = t_axis;
		next_x_value = x_value;
		next_y_value = y_value;
		ce_write = 1'b0;
		if (frame_start) begin
			{next_t_clk, next_t_par, next_t_axis} = 3'h0; // RULE23
		end
		if (state == acspi_pkg::ACSPI_FRAME && frame_end) begin
			{next_t_clk, next_t_par, next_t_axis} = {clk_f, par_f, axis_f}; // RULE23
			// Master encodes the op in bits 13:12 of a type-00 word
			if (!xfer_exc && shift_in[15:14] == acspi_pkg::ACSPI_XT_REG) begin // RULE7 RULE13
				if (shift_in[13:12] == 2'b01) begin
					next_pointer = shift_in[7:0];
				end else if (shift_in[13:12] == 2'b11 && pointer == `ACSPI_ADDR_DEVICE_CONTROL) begin
					next_device_control = shift_in[7:0]; // RULE16 RULE17
					next_device_control[`ACSPI_CE_BIT] = 1'b0; // Clear bit acts, never stored
					ce_write = shift_in[`ACSPI_CE_BIT];
				end
			end
		end
		if (fifo_valid && fifo_ready) begin
			if (fifo_out.axis_y) begin
				next_y_value = fifo_out.value;
			end else begin
				next_x_value = fifo_out.value;
			end
		end
		next_reset_latched_flag = reset_latched_flag && !ce_write;
		next_overtemp_flag = overtemp_detect || (overtemp_flag && !ce_write); // Set wins
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			pointer <= 8'h00;
			device_control <= `ACSPI_DEVICE_CONTROL_RST;
			reset_latched_flag <= 1'b1;
			overtemp_flag <= 1'b0;
			{t_clk, t_par, t_axis} <= 3'h0;
			x_value <= 11'h000;
			y_value <= 11'h000;
		end else begin
			pointer <= next_pointer;
			device_control <= next_device_control;
			reset_latched_flag <= next_reset_latched_flag;
			overtemp_flag <= next_overtemp_flag;
			{t_clk, t_par, t_axis} <= {next_t_clk, next_t_par, next_t_axis};
			x_value <= next_x_value;
			y_value <= next_y_value;
		end
	end

	// =============================================================
	// Response word for the command of the previous frame
	always_comb begin
		crit = fuse_integrity_flag || osc_fault || init_pending_flag || reset_latched_flag
			|| overtemp_flag || offset_fault_x || offset_fault_y;
		trans = t_clk || t_par || t_axis;
		beh_one = selftest_active ^ hold_s; // RULE3 RULE12
		is_acc = (last_cmd[15:14] != acspi_pkg::ACSPI_XT_REG);
		// Class ranking; behavioral pair falls through to none
		if (trans) cls = acspi_pkg::ACSPI_EC_TRANS; // RULE8
		else if (crit) cls = acspi_pkg::ACSPI_EC_CRIT; // RULE9
		else if (beh_one) cls = acspi_pkg::ACSPI_EC_BEH; // RULE11
		else cls = acspi_pkg::ACSPI_EC_NONE; // RULE18
		// Single winning status code
		if (t_clk) code = `ACSPI_SC_CLK; // RULE1
		else if (t_par) code = `ACSPI_SC_PAR;
		else if (fuse_integrity_flag) code = `ACSPI_SC_DATA;
		else if (osc_fault) code = `ACSPI_SC_OSC;
		else if (init_pending_flag) code = `ACSPI_SC_INIT;
		else if (reset_latched_flag) code = `ACSPI_SC_RESET;
		else if (overtemp_flag) code = `ACSPI_SC_TEMP;
		else if (offset_fault_x) code = `ACSPI_SC_OFFX; // RULE2
		else if (offset_fault_y) code = `ACSPI_SC_OFFY;
		else code = `ACSPI_SC_AXIS;
		// Readable registers
		if (pointer == `ACSPI_ADDR_DEVICE_CONTROL) rdata = device_control;
		else if (pointer == `ACSPI_ADDR_STATUS) rdata = {fuse_integrity_flag, osc_fault,
			init_pending_flag, reset_latched_flag, overtemp_flag, offset_fault_x,
			offset_fault_y && !offset_fault_x, hold_s}; // RULE2
		else rdata = 8'h00;
		// Acceleration payload
		if (trans) acc_value = t_clk ? `ACSPI_ACC_CLK : (t_par ? `ACSPI_ACC_PAR : `ACSPI_ACC_AXIS);
		else if (crit) acc_value = `ACSPI_ACC_CRIT; // RULE9
		else acc_value = last_cmd[14] ? x_value : y_value; // RULE10
		if (is_acc) begin
			resp_word = {cls != acspi_pkg::ACSPI_EC_NONE, // RULE14 RULE11
				(trans || crit) ? 2'b11 : last_cmd[15:14], 1'b0, acc_value, 1'b0};
			resp_word[`ACSPI_ACC_PBIT] = ~^resp_word; // RULE21
		end else begin
			resp_word = {(cls == acspi_pkg::ACSPI_EC_NONE) ? 3'h0 : 3'h7, // RULE15
				last_cmd[13:12], 1'b0, cls, 8'h00};
			if (trans) resp_word[7:0] = code; // RULE8
			else if (last_cmd[13:12] == 2'b00) resp_word[7:0] = pointer;
			else if (last_cmd[13:12] == 2'b10) resp_word[7:0] = rdata;
			else if (last_cmd[13:12] == 2'b11) resp_word[7:0] = pointer;
			resp_word[`ACSPI_REG_PBIT] = ~^resp_word; // RULE21
		end
	end

	// =============================================================
	// Sample buffer; ready reaches the datapath while frames stall draining
	acspi_fifo #(
		.WIDTH($bits(acspi_pkg::acspi_sample_t)),
		.DEPTH(`ACSPI_FIFO_DEPTH)
	) u_fifo (
		.clk(clk),
		.rst_n(rst_n),
		.in_valid(sample_valid),
		.in_data(sample_data),
		.in_ready(sample_ready),
		.out_valid(fifo_valid),
		.out_data(fifo_out),
		.out_ready(fifo_ready)
	);

	// =============================================================
	// Checks
	chk_resp_odd: assert property (@(posedge clk) disable iff (!rst_n) // RULE21
		frame_start |=> ^shift_out) else $error("Loaded response has even parity");
	chk_edge_count: assert property (@(posedge clk) disable iff (!rst_n) // RULE22
		(state == acspi_pkg::ACSPI_FRAME && frame_end && edge_cnt != 5'h10) |=> t_clk)
		else $error("Wrong edge count not flagged");
	chk_write_gated: assert property (@(posedge clk) disable iff (!rst_n) // RULE7
		(state == acspi_pkg::ACSPI_FRAME && frame_end && xfer_exc) |=> $stable(pointer))
		else $error("Pointer written despite exception");
	chk_only_device_control: assert property (@(posedge clk) disable iff (!rst_n) // RULE16
		(frame_end && pointer != 8'h0e) |=> $stable(device_control))
		else $error("Non-control register written");
	chk_axis_bad: assert property (@(posedge clk) disable iff (!rst_n) // RULE6
		(state == acspi_pkg::ACSPI_FRAME && frame_end && shift_in[15:14] == 2'b11)
		|=> t_axis) else $error("Invalid axis not latched");
	chk_trans_resp: assert property (@(posedge clk) disable iff (!rst_n) // RULE8
		(frame_start && state == acspi_pkg::ACSPI_IDLE && trans)
		|=> shift_out[15:13] == 3'h7 && !miso_oe_n) else $error("Transient status missing");
	chk_crit_accel: assert property (@(posedge clk) disable iff (!rst_n) // RULE9
		(frame_start && state == acspi_pkg::ACSPI_IDLE && !trans && crit && is_acc)
		|=> shift_out[11:1] == 11'h7ff) else $error("Critical value not returned");
	chk_beh_flag: assert property (@(posedge clk) disable iff (!rst_n) // RULE11
		(frame_start && state == acspi_pkg::ACSPI_IDLE && !trans && !crit && is_acc)
		|=> shift_out[15] == $past(beh_one)) else $error("Behavioral flag wrong");
	chk_trans_clear: assert property (@(posedge clk) disable iff (!rst_n) // RULE23
		(frame_start && state == acspi_pkg::ACSPI_IDLE) |=> !t_clk && !t_par && !t_axis)
		else $error("Transient fault not cleared");
	cov_clean_frame: cover property (@(posedge clk) disable iff (!rst_n)
		frame_end && state == acspi_pkg::ACSPI_FRAME && !xfer_exc);
	cov_ctl_write: cover property (@(posedge clk) disable iff (!rst_n)
		frame_end && !xfer_exc && shift_in[15:12] == 4'h3 && pointer == 8'h0e);
	cov_fifo_full: cover property (@(posedge clk) disable iff (!rst_n) !sample_ready);
	cov_both_beh: cover property (@(posedge clk) disable iff (!rst_n)
		frame_start && hold_s && selftest_active);

endmodule

// *** verification/acspi_master.sv ***
// SPI master model that frames one 16-bit command and collects the reply
`timescale 1ns/100ps

module acspi_master (
	// Serial pins driven by the master
	output logic sclk,
	output logic cs_n,
	output logic mosi,
	// Serial pins driven by the device
	input wire logic miso,
	input wire logic miso_oe_n
);
	// =============================================================
	// Idle levels: clock stands low, select high outside frames
	initial begin
		sclk = 1'h0;
		cs_n = 1'h1;
		mosi = 1'h0;
	end

	// =============================================================
	// One frame; nrise other than 16 or hi_start set breaks the framing on purpose
	task automatic xfer(input logic [15:0] cmd, input int nrise, input logic hi_start,
		output logic [15:0] resp);
		resp = 16'h0000;
		sclk = hi_start;
		#40 cs_n = 1'h0;
		#40 sclk = 1'h0;
		for (int i = 0; i < nrise; i++) begin
			mosi = cmd[(15 - i) & 15];
			// An undriven reply pin reads as unknown so it can never match
			#40 resp = {resp[14:0], miso_oe_n ? 1'hx : miso};
			sclk = 1'h1;
			#40 sclk = 1'h0;
		end
		#40 cs_n = 1'h1;
		mosi = ~mosi; // Deselected line does not keep the last bit
		#40;
	endtask
endmodule

// *** verification/accel_spi_cmd_response_tb.sv ***
// Self-checking bench for the SPI command decoder and response formatter
`timescale 1ns/100ps

module accel_spi_cmd_response_tb;
	// =============================================================
	// Signals
	logic clk = 1'h0;
	logic rst_n = 1'h0;
	logic sclk, cs_n, mosi, miso, miso_oe_n, sample_ready;
	logic sample_valid = 1'h0;
	acspi_pkg::acspi_sample_t sample_data = '0;
	logic overtemp_detect = 1'h0;
	logic offset_fault_x = 1'h0;
	logic offset_fault_y = 1'h0;
	logic capture_hold_input = 1'h0;
	logic [15:0] rsp;
	int err_count = 0;
	int tests_run = 0;
	int n;

	// 200 MHz clock
	always #2.5 clk = ~clk;

	// =============================================================
	// Design and master model; fault sources not exercised stay low
	acspi_core i_dut (
		.clk(clk), .rst_n(rst_n), .sclk(sclk), .cs_n(cs_n), .mosi(mosi),
		.miso(miso), .miso_oe_n(miso_oe_n), .sample_valid(sample_valid),
		.sample_data(sample_data), .sample_ready(sample_ready),
		.fuse_integrity_flag(1'h0), .osc_fault(1'h0), .init_pending_flag(1'h0),
		.overtemp_detect(overtemp_detect), .offset_fault_x(offset_fault_x),
		.offset_fault_y(offset_fault_y), .capture_hold_input(capture_hold_input)
	);
	acspi_master i_master (
		.sclk(sclk), .cs_n(cs_n), .mosi(mosi), .miso(miso), .miso_oe_n(miso_oe_n)
	);

	// =============================================================
	// Word builders: parity bit chosen for an odd count of ones
	function automatic logic [15:0] odd(input logic [15:0] w, input int pos);
		w[pos] = 1'h0;
		w[pos] = ~^w;
		return w;
	endfunction
	function automatic logic [15:0] regw(input logic [2:0] s, input logic [1:0] op,
		input logic [1:0] ec, input logic [7:0] b);
		return odd({s, op, 1'h0, ec, b}, 10);
	endfunction
	function automatic logic [15:0] accw(input logic [2:0] h, input logic [10:0] v);
		return odd({h, 1'h0, v, 1'h0}, 12);
	endfunction
	function automatic logic [15:0] pw(input logic [7:0] a);
		return odd({8'h10, a}, 10);
	endfunction
	function automatic logic [15:0] dw(input logic [7:0] d);
		return odd({8'h30, d}, 10);
	endfunction

	// =============================================================
	// Shared tasks
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		tests_run++;
		if (seen !== exp) begin
			err_count++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	// Frame a command and compare the reply, which answers the previous command
	task automatic sc(input logic [15:0] cmd, input logic [15:0] exp);
		i_master.xfer(cmd, 16, 1'h0, rsp);
		check(rsp, exp);
	endtask

	// Offer samples for a number of cycles, counting those taken
	task automatic feed(input logic [11:0] base, input int tries, output int cnt);
		logic take;
		@(posedge clk);
		#1 cnt = 0;
		sample_valid = 1'h1;
		for (int i = 0; i < tries; i++) begin
			sample_data = base + 12'(cnt);
			// Ready is registered, so its settled value decides the coming edge
			take = sample_ready;
			@(posedge clk);
			if (take === 1'h1) cnt++;
			#1;
		end
		sample_valid = 1'h0;
	endtask

	// =============================================================
	// Scenarios
	task automatic t_reset();
		check({15'h0000, miso_oe_n}, 16'h0001);
		sc(pw(8'h0e), regw(3'h7, 2'h0, 2'h2, 8'h00));
		sc(dw(8'h01), regw(3'h7, 2'h1, 2'h2, 8'h00));
		sc(16'h0400, regw(3'h0, 2'h3, 2'h0, 8'h0e));
		sc(16'h2000, regw(3'h0, 2'h0, 2'h0, 8'h0e));
		sc(pw(8'h20), regw(3'h0, 2'h2, 2'h0, 8'h00));
		sc(dw(8'h55), regw(3'h0, 2'h1, 2'h0, 8'h00));
		sc(pw(8'h0e), regw(3'h0, 2'h3, 2'h0, 8'h20));
		$display("t_reset done");
	endtask

	task automatic t_accel();
		feed(12'h123, 1, n);
		feed(12'hc56, 1, n);
		repeat (4) @(posedge clk);
		#1 sc(16'h4000, regw(3'h0, 2'h1, 2'h0, 8'h00));
		sc(16'h8000, accw(3'h1, 11'h123));
		sc(16'h4000, accw(3'h2, 11'h456));
		$display("t_accel done");
	endtask

	// The frame stalls the drain, so the buffer fills until it refuses
	task automatic t_fill();
		logic rdy;
		fork
			i_master.xfer(16'h4000, 16, 1'h0, rsp);
			begin
				repeat (20) @(posedge clk);
				feed(12'h100, 40, n);
				rdy = sample_ready;
			end
		join
		check(rsp, accw(3'h1, 11'h123));
		check(16'(n), 16'h0020);
		check({15'h0000, rdy}, 16'h0000);
		repeat (50) @(posedge clk);
		#1 check({15'h0000, sample_ready}, 16'h0001);
		sc(16'h0400, accw(3'h1, 11'h11f));
		$display("t_fill done");
	endtask

	task automatic t_trans();
		sc(16'hc001, regw(3'h0, 2'h0, 2'h0, 8'h0e));
		sc(16'h4000, accw(3'h7, 11'h7fe));
		sc(16'h2001, accw(3'h1, 11'h11f));
		overtemp_detect = 1'h1;
		sc(16'h4001, regw(3'h7, 2'h2, 2'h3, 8'h02));
		sc(16'h0400, accw(3'h7, 11'h001));
		sc(16'h4000, regw(3'h7, 2'h0, 2'h2, 8'h0e));
		overtemp_detect = 1'h0;
		sc(dw(8'h01), accw(3'h7, 11'h7ff));
		sc(16'h0400, regw(3'h0, 2'h3, 2'h0, 8'h0e));
		$display("t_trans done");
	endtask

	task automatic t_clock();
		i_master.xfer(pw(8'h0f), 15, 1'h0, rsp);
		i_master.xfer(16'h0400, 16, 1'h0, rsp);
		check({rsp[15:13], 3'h0, rsp[9:0]}, {3'h7, 3'h0, 2'h3, 8'h01});
		sc(16'h2000, regw(3'h0, 2'h0, 2'h0, 8'h0e));
		i_master.xfer(16'h0400, 16, 1'h1, rsp);
		sc(16'h2000, regw(3'h7, 2'h0, 2'h3, 8'h01));
		$display("t_clock done");
	endtask

	task automatic t_behav();
		capture_hold_input = 1'h1;
		repeat (4) @(posedge clk);
		#1 sc(16'h4000, regw(3'h7, 2'h2, 2'h1, 8'h00));
		sc(dw(8'h02), accw(3'h5, 11'h11f));
		sc(16'h4000, regw(3'h0, 2'h3, 2'h0, 8'h0e));
		sc(16'h4000, accw(3'h1, 11'h11f));
		capture_hold_input = 1'h0;
		repeat (4) @(posedge clk);
		#1 sc(16'h2000, accw(3'h5, 11'h11f));
		sc(dw(8'h00), regw(3'h7, 2'h2, 2'h1, 8'h02));
		$display("t_behav done");
	endtask

	task automatic t_offset();
		offset_fault_x = 1'h1;
		offset_fault_y = 1'h1;
		i_master.xfer(pw(8'h0f), 16, 1'h0, rsp);
		i_master.xfer(16'h2000, 16, 1'h0, rsp);
		sc(16'h0400, regw(3'h7, 2'h2, 2'h2, 8'h04));
		offset_fault_x = 1'h0;
		offset_fault_y = 1'h0;
		$display("t_offset done");
	endtask

	// =============================================================
	// Verdict and end of run
	task automatic report_and_stop();
		$display("Comparisons %0d, mismatches %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	// Main sequence; inputs change 1 ns after the clock edge
	initial begin
		repeat (20) @(posedge clk);
		#1 rst_n = 1'h1;
		repeat (5) @(posedge clk);
		#1 t_reset();
		t_accel();
		t_fill();
		t_trans();
		t_clock();
		t_behav();
		t_offset();
		report_and_stop();
	end

	// Watchdog: the run needs about 49 us, so 200 us means a hang
	initial begin
		#200000;
		err_count++;
		report_and_stop();
	end
endmodule
